// *** rtl/adc_sequence_control.sv ***
// Sample/convert sequencer for a 10-bit converter with an APB register file
// Functional notes
// - Enable bit runs or stops the converter
// - Idle-stop bit halts operation during idle mode
// - Codes 111/110: 32-bit left-justified fractions
// - Codes 101/100: 32-bit right-justified integers
// - Codes 011/010: 16-bit left-justified fractions
// - Code 000: unsigned right-justified, upper bits zero
// - Code 111 auto-converts after sample counter
// - Charge unit, timer, or pin edge triggers
// - Manual: writing sample bit zero starts conversion
// - Stop-on-interrupt clears auto-start at interrupt
// - Otherwise sequences continue, overwriting old results
// - Auto-start re-arms sampling after each conversion
// - With auto-start clear, writing sample bit one starts sampling
// - Nonzero trigger: hardware clears sample bit
// - Done sets at finish, clears at start
// - Software clears done; conversion unaffected
// - Reference field selects high/low references
// - Offset calibration ties inputs to low reference
// - Scan bit steps inputs each sample
// - Fill-status shows half being filled
// - Interrupt after every interval-plus-one sequences
// - Control register upper halves and gaps read zero
// - Auto sample time counts conversion clocks
// - Conversion clock is 2*(div+1) bus clocks
`timescale 1ns/1ns
module adc_sequence_control #(
  parameter int ADDR_W = 8
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rstn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ADDR_W-1:0]              paddr,
  input  wire logic [adc_seq_pkg::DATA_W-1:0] pwdata,
  output logic      [adc_seq_pkg::DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           idleMode,
  input  wire logic                           extIntPin,
  input  wire logic                           timerMatch,
  input  wire logic                           chargeTimeTrig,
  input  wire logic                           convDone,
  input  wire logic [adc_seq_pkg::RES_W-1:0]  convResult,
  output logic                                sampling,
  output logic                                convStart,
  output logic                                convClkTick,
  output logic                                convIrq,
  output logic                                scanStep,
  output logic                                highRefExternal,
  output logic                                lowRefExternal,
  output logic                                offsetCalActive,
  output logic                                alternateInputMode,
  output logic                                bufferFillStatus,
  output logic [3:0]                          bufferEntry,
  output logic [adc_seq_pkg::DATA_W-1:0]      resultData
);
  import adc_seq_pkg::*;

  typedef struct packed {
    logic              on;
    logic              idleStop;
    logic [2:0]        form;
    logic [2:0]        ssrc;
    logic              stop_on_first_interrupt;
    logic              auto_sample_start;
    logic              sample_enable;
    logic              done;
    logic [2:0]        vcfg;
    logic              offset_calibration;
    logic              scanEn;
    logic              buffer_fill_status;
    logic [3:0]        smpi;
    logic              split_buffer_mode;
    logic              alternate_input_mode;
    logic              conversion_clock_source;
    logic [4:0]        samc;
    logic [7:0]        adcs;
    seq_state_t        state;
    logic [8:0]        divCnt;
    logic              tadTick;
    logic [4:0]        smpCnt;
    logic [3:0]        seqCnt;
    logic              convStart;
    logic              convIrq;
    logic              scanStep;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] rdata;
    logic [2:0]        extSync;
    logic              extLevel;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  logic       active;
  logic       apbAccess;
  logic       wrOne;
  logic       wrTwo;
  logic       wrClock;
  logic       addrHit;
  logic       swEnd;
  logic       extEdge;
  logic       autoEnd;
  logic       trig;
  logic       loadResult;
  logic [4:0] samcEff;

  // Signed forms treat the raw code as offset binary: flipping the MSB
  // gives the two's complement of (code - midscale).
  function automatic logic [DATA_W-1:0] fmtResult(
    input logic [2:0]       f,
    input logic [RES_W-1:0] d
  );
    logic s;
    s = ~d[RES_W-1];
    case (f)
      FMT_SFRAC32: fmtResult = {s, d[8:0], 22'h000000};
      FMT_FRAC32:  fmtResult = {d, 22'h000000};
      FMT_SINT32:  fmtResult = {{22{s}}, s, d[8:0]};
      FMT_INT32:   fmtResult = {22'h000000, d};
      FMT_SFRAC16: fmtResult = {16'h0000, s, d[8:0], 6'h00};
      FMT_FRAC16:  fmtResult = {16'h0000, d, 6'h00};
      FMT_SINT16:  fmtResult = {16'h0000, {6{s}}, s, d[8:0]};
      default:     fmtResult = {22'h000000, d};
    endcase
  endfunction : fmtResult

  // Halted either by the enable bit or by idle with idle-stop set
  assign active = st_reg.on && !(st_reg.idleStop && idleMode);

  assign apbAccess = psel && penable;
  assign addrHit   = (paddr == ADDR_W'(OFF_CTRL_ONE)) ||
                     (paddr == ADDR_W'(OFF_CTRL_TWO)) ||
                     (paddr == ADDR_W'(OFF_CLOCK))    ||
                     (paddr == ADDR_W'(OFF_RESULT));
  assign wrOne   = apbAccess && pwrite && paddr == ADDR_W'(OFF_CTRL_ONE);
  assign wrTwo   = apbAccess && pwrite && paddr == ADDR_W'(OFF_CTRL_TWO);
  assign wrClock = apbAccess && pwrite && paddr == ADDR_W'(OFF_CLOCK);

  assign pready  = 1'b1;
  assign pslverr = apbAccess && !addrHit;
  assign prdata  = st_reg.rdata;

  // Manual end of sampling: a zero written over a set sample bit
  assign swEnd = wrOne && !pwdata[SAMPLE_ENABLE_BIT] && st_reg.sample_enable &&
                 st_reg.ssrc == TRIG_MANUAL;

  // Pin edge counts only once the two late stages agree
  assign extEdge = (st_reg.extSync[1] == st_reg.extSync[2]) &&
                   st_reg.extSync[2] && !st_reg.extLevel;

  // A zero sample time is not allowed; it is run as one clock
  assign samcEff = (st_reg.samc == 5'h00) ? SAMC_MIN : st_reg.samc;
  assign autoEnd = st_reg.sample_enable && st_reg.tadTick &&
                   (st_reg.smpCnt + 5'h01 >= samcEff);

  always_comb
  begin
    case (st_reg.ssrc)
      TRIG_MANUAL: trig = swEnd;
      TRIG_EXT:    trig = extEdge;
      TRIG_TIMER:  trig = timerMatch;
      TRIG_CHARGE: trig = chargeTimeTrig;
      TRIG_AUTO:   trig = autoEnd;
      default:     trig = 1'b0;
    endcase
  end

  assign loadResult = st_reg.on && st_reg.state == ST_CONVERT &&
                      convDone;

  always_comb
  begin
    st_next = st_reg;
    st_next.convStart = 1'b0;
    st_next.convIrq   = 1'b0;
    st_next.scanStep  = 1'b0;
    st_next.tadTick   = 1'b0;

    st_next.extSync = {st_reg.extSync[1:0], extIntPin};
    if (st_reg.extSync[1] == st_reg.extSync[2])
      st_next.extLevel = st_reg.extSync[2];

    // Conversion clock: one tick every 2*(div+1) bus clocks
    if (st_reg.divCnt == {st_reg.adcs, 1'b1})
    begin
      st_next.divCnt  = 9'h000;
      st_next.tadTick = 1'b1;
    end
    else
      st_next.divCnt = st_reg.divCnt + 9'h001;

    if (wrOne)
    begin
      st_next.on       = pwdata[ON_BIT];
      st_next.idleStop = pwdata[IDLE_STOP_BIT];
      st_next.form     = pwdata[FORM_LSB +: 3];
      st_next.ssrc     = pwdata[SSRC_LSB +: 3];
      st_next.stop_on_first_interrupt  = pwdata[STOP_ON_FIRST_INTERRUPT_BIT];
      st_next.auto_sample_start     = pwdata[AUTO_SAMPLE_START_BIT];
      if (!pwdata[DONE_BIT])
        st_next.done = 1'b0;
      if (pwdata[SAMPLE_ENABLE_BIT] && !st_reg.auto_sample_start && st_reg.on &&
          st_reg.state == ST_IDLE)
        st_next.sample_enable = 1'b1;
      else if (!pwdata[SAMPLE_ENABLE_BIT] && st_reg.ssrc == TRIG_MANUAL)
        st_next.sample_enable = 1'b0;
    end
    if (wrTwo)
    begin
      st_next.vcfg   = pwdata[VCFG_LSB +: 3];
      st_next.offset_calibration = pwdata[OFFSET_CALIBRATION_BIT];
      st_next.scanEn = pwdata[SCAN_ENABLE_BIT];
      st_next.smpi   = pwdata[SMPI_LSB +: 4];
      st_next.split_buffer_mode   = pwdata[SPLIT_BUFFER_MODE_BIT];
      st_next.alternate_input_mode   = pwdata[ALTERNATE_INPUT_MODE_BIT];
    end
    if (wrClock)
    begin
      st_next.conversion_clock_source = pwdata[CONVERSION_CLOCK_SOURCE_BIT];
      st_next.samc = pwdata[SAMC_LSB +: 5];
      st_next.adcs = pwdata[ADCS_LSB +: 8];
    end

    // Sample length counter only matters for the auto trigger
    if (!st_reg.sample_enable || st_reg.ssrc != TRIG_AUTO)
      st_next.smpCnt = 5'h00;
    else if (active && st_reg.tadTick && !autoEnd)
      st_next.smpCnt = st_reg.smpCnt + 5'h01;

    // End of sampling and start of conversion
    if (active && st_reg.sample_enable && st_reg.state == ST_IDLE && trig)
    begin
      st_next.sample_enable      = 1'b0;
      st_next.smpCnt    = 5'h00;
      st_next.convStart = 1'b1;
      st_next.done      = 1'b0;
      st_next.state     = ST_CONVERT;
      st_next.scanStep  = st_reg.scanEn;
    end

    // Completion; hardware set wins over a same-cycle software clear
    if (loadResult)
    begin
      st_next.state  = ST_IDLE;
      st_next.done   = 1'b1;
      st_next.result = fmtResult(st_reg.form, convResult);
      if (st_reg.seqCnt == st_reg.smpi)
      begin
        st_next.seqCnt  = 4'h0;
        st_next.convIrq = 1'b1;
        if (st_reg.split_buffer_mode)
          st_next.buffer_fill_status = ~st_reg.buffer_fill_status;
        if (st_reg.stop_on_first_interrupt)
          st_next.auto_sample_start = 1'b0;
      end
      else
        st_next.seqCnt = st_reg.seqCnt + 4'h1;
      if (st_next.auto_sample_start)
        st_next.sample_enable = 1'b1;
    end

    if (!st_reg.on)
    begin
      st_next.done   = 1'b0;
      st_next.sample_enable   = 1'b0;
      st_next.seqCnt = 4'h0;
      st_next.smpCnt = 5'h00;
      st_next.buffer_fill_status   = 1'b0;
      st_next.state  = ST_IDLE;
      st_next.divCnt = 9'h000;
    end

    // Read data is captured in the setup phase so the access is zero-wait
    if (psel && !penable)
    begin
      st_next.rdata = '0;
      case (paddr)
        ADDR_W'(OFF_CTRL_ONE):
        begin
          st_next.rdata[ON_BIT]       = st_reg.on;
          st_next.rdata[IDLE_STOP_BIT]     = st_reg.idleStop;
          st_next.rdata[FORM_LSB +: 3] = st_reg.form;
          st_next.rdata[SSRC_LSB +: 3] = st_reg.ssrc;
          st_next.rdata[STOP_ON_FIRST_INTERRUPT_BIT]  = st_reg.stop_on_first_interrupt;
          st_next.rdata[AUTO_SAMPLE_START_BIT]     = st_reg.auto_sample_start;
          st_next.rdata[SAMPLE_ENABLE_BIT]     = st_reg.sample_enable;
          st_next.rdata[DONE_BIT]     = st_reg.done;
        end
        ADDR_W'(OFF_CTRL_TWO):
        begin
          st_next.rdata[VCFG_LSB +: 3] = st_reg.vcfg;
          st_next.rdata[OFFSET_CALIBRATION_BIT]   = st_reg.offset_calibration;
          st_next.rdata[SCAN_ENABLE_BIT]    = st_reg.scanEn;
          st_next.rdata[BUFFER_FILL_STATUS_BIT]     = st_reg.buffer_fill_status;
          st_next.rdata[SMPI_LSB +: 4] = st_reg.smpi;
          st_next.rdata[SPLIT_BUFFER_MODE_BIT]     = st_reg.split_buffer_mode;
          st_next.rdata[ALTERNATE_INPUT_MODE_BIT]     = st_reg.alternate_input_mode;
        end
        ADDR_W'(OFF_CLOCK):
        begin
          st_next.rdata[CONVERSION_CLOCK_SOURCE_BIT]     = st_reg.conversion_clock_source;
          st_next.rdata[SAMC_LSB +: 5] = st_reg.samc;
          st_next.rdata[ADCS_LSB +: 8] = st_reg.adcs;
        end
        ADDR_W'(OFF_RESULT):
          st_next.rdata = st_reg.result;
        default:
          st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_reg       <= '0;
      st_reg.state <= ST_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign sampling           = st_reg.sample_enable;
  assign convStart          = st_reg.convStart;
  assign convClkTick        = st_reg.tadTick;
  assign convIrq            = st_reg.convIrq;
  assign scanStep           = st_reg.scanStep;
  // Codes with the top bit set fall back to the supply rails
  assign highRefExternal    = !st_reg.vcfg[2] && st_reg.vcfg[0];
  assign lowRefExternal     = !st_reg.vcfg[2] && st_reg.vcfg[1];
  assign offsetCalActive    = st_reg.offset_calibration;
  assign alternateInputMode = st_reg.alternate_input_mode;
  assign bufferFillStatus   = st_reg.buffer_fill_status;
  assign bufferEntry        = st_reg.split_buffer_mode ?
                              {st_reg.buffer_fill_status, st_reg.seqCnt[2:0]} :
                              st_reg.seqCnt;
  assign resultData         = st_reg.result;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_disable_clears: assert property (
    !st_reg.on |=> !st_reg.done && !st_reg.sample_enable && st_reg.seqCnt == 4'h0)
    else $error("disabled module kept done, sample or count");

  a_idle_halt: assert property (
    st_reg.on && st_reg.idleStop && idleMode |=> !convStart)
    else $error("conversion started while halted in idle");

  a_start_done: assert property (
    convStart |-> !st_reg.done && st_reg.state == ST_CONVERT)
    else $error("done not cleared at conversion start");

  a_finish_done: assert property (
    loadResult |=> st_reg.done && st_reg.state == ST_IDLE)
    else $error("done not set at conversion finish");

  a_hw_clear_sample_enable: assert property (
    convStart && st_reg.ssrc != TRIG_MANUAL |-> !st_reg.sample_enable)
    else $error("sample bit left set at hardware trigger");

  a_manual_start: assert property (
    swEnd && active && st_reg.state == ST_IDLE |=> convStart ##1 !convStart)
    else $error("manual end of sampling did not start conversion");

  a_auto_restart: assert property (
    loadResult && st_reg.auto_sample_start && !(st_reg.stop_on_first_interrupt &&
      st_reg.seqCnt == st_reg.smpi) |=> st_reg.sample_enable)
    else $error("auto-start did not re-arm sampling");

  a_stop_on_irq: assert property (
    convIrq && st_reg.stop_on_first_interrupt |-> !st_reg.auto_sample_start ##1 !st_reg.sample_enable)
    else $error("auto-start survived the first interrupt");

  a_irq_interval: assert property (
    loadResult && st_reg.seqCnt == st_reg.smpi |=>
      convIrq && st_reg.seqCnt == 4'h0)
    else $error("interrupt missing at end of interval");

  a_no_early_irq: assert property (
    loadResult && st_reg.seqCnt != st_reg.smpi |=> !convIrq)
    else $error("interrupt raised before end of interval");

  a_upper_zero: assert property (
    psel && !penable && paddr != ADDR_W'(OFF_RESULT) |=>
      prdata[DATA_W-1:HALF_W] == 16'h0000)
    else $error("unimplemented upper bits read nonzero");

  a_int_format: assert property (
    loadResult && st_reg.form == FMT_INT16 |=>
      resultData[DATA_W-1:RES_W] == 22'h000000)
    else $error("unsigned 16-bit result has upper bits set");

  a_tick_spacing: assert property (
    convClkTick && st_reg.on && $stable(st_reg.adcs) &&
      st_reg.adcs == 8'h00 |=> !convClkTick ##1 convClkTick)
    else $error("conversion clock period wrong for zero divider");

  c_manual_cycle: cover property (swEnd ##[1:20] convDone);
  c_auto_restart: cover property (loadResult && st_reg.auto_sample_start ##1 sampling);
  c_irq_stop: cover property (convIrq && st_reg.stop_on_first_interrupt);
  c_split_flip: cover property (convIrq && st_reg.split_buffer_mode);
endmodule : adc_sequence_control

// *** rtl/adc_seq_pkg.sv ***
// Constants, register map and state codes for the converter sequencer
package adc_seq_pkg;
  localparam int         DATA_W       = 32;
  localparam int         RES_W        = 10;
  localparam int         HALF_W       = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_CLOCK    = 8'h08;
  localparam logic [7:0] OFF_RESULT   = 8'h0C;

  // Control one fields
  localparam int ON_BIT      = 15;
  localparam int IDLE_STOP_BIT    = 13;
  localparam int FORM_LSB    = 8;
  localparam int SSRC_LSB    = 5;
  localparam int STOP_ON_FIRST_INTERRUPT_BIT = 4;
  localparam int AUTO_SAMPLE_START_BIT    = 2;
  localparam int SAMPLE_ENABLE_BIT    = 1;
  localparam int DONE_BIT    = 0;

  // Control two fields
  localparam int VCFG_LSB    = 13;
  localparam int OFFSET_CALIBRATION_BIT  = 12;
  localparam int SCAN_ENABLE_BIT   = 10;
  localparam int BUFFER_FILL_STATUS_BIT    = 7;
  localparam int SMPI_LSB    = 2;
  localparam int SPLIT_BUFFER_MODE_BIT    = 1;
  localparam int ALTERNATE_INPUT_MODE_BIT    = 0;

  // Clock register fields
  localparam int CONVERSION_CLOCK_SOURCE_BIT    = 15;
  localparam int SAMC_LSB    = 8;
  localparam int ADCS_LSB    = 0;

  // Output formats
  localparam logic [2:0] FMT_INT16   = 3'h0;
  localparam logic [2:0] FMT_SINT16  = 3'h1;
  localparam logic [2:0] FMT_FRAC16  = 3'h2;
  localparam logic [2:0] FMT_SFRAC16 = 3'h3;
  localparam logic [2:0] FMT_INT32   = 3'h4;
  localparam logic [2:0] FMT_SINT32  = 3'h5;
  localparam logic [2:0] FMT_FRAC32  = 3'h6;
  localparam logic [2:0] FMT_SFRAC32 = 3'h7;

  // Trigger sources
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_EXT    = 3'h1;
  localparam logic [2:0] TRIG_TIMER  = 3'h2;
  localparam logic [2:0] TRIG_CHARGE = 3'h3;
  localparam logic [2:0] TRIG_AUTO   = 3'h7;

  localparam logic [4:0] SAMC_MIN    = 5'h01;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01
  } seq_state_t;
endpackage : adc_seq_pkg

// *** bench/conv_core_model.sv ***
// Behavioural converter core that answers each start with a coded result
`timescale 1ns/1ns
module conv_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       convStart,
  input  wire logic [7:0] lat,
  input  wire logic [9:0] code,
  output logic            convDone,
  output logic [9:0]      convResult
);
  logic [7:0] cnt;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cnt        <= 8'h00;
      convDone   <= 1'b0;
      convResult <= 10'h000;
    end
    else
    begin
      convDone <= 1'b0;
      // Result holds only with the pulse; scrambled so stale use shows
      if (convDone)
        convResult <= ~convResult;
      if (convStart)
        cnt <= lat;
      else if (cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          convDone   <= 1'b1;
          convResult <= code;
        end
      end
    end
  end
endmodule : conv_core_model

// *** bench/tb_top.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module tb_top;
  import adc_seq_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        idleMode = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [7:0]  lat     = 8'h01;
  logic [31:0] pwdata  = 32'h0;
  logic [2:0]  trig    = 3'h0;
  logic [9:0]  code    = 10'h135;
  logic [31:0] prdata, rd;
  logic [9:0]  convResult;
  logic        pready, pslverr, err, convDone, convStart, convIrq;
  logic        sampling, scanStep, hiExt, loExt, offset_calibration;
  logic        altsSeen, fillSeen;
  logic [31:0] resData;
  int          cnt[4] = '{0, 0, 0, 0};
  int          mismatches = 0;
  int          nTests = 0;
  int          cyc = 0;

  adc_sequence_control uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idleMode(idleMode), .extIntPin(trig[0]), .timerMatch(trig[1]),
    .chargeTimeTrig(trig[2]), .convDone(convDone),
    .convResult(convResult), .sampling(sampling), .convStart(convStart),
    .convClkTick(), .convIrq(convIrq), .scanStep(scanStep),
    .highRefExternal(hiExt), .lowRefExternal(loExt),
    .offsetCalActive(offset_calibration), .alternateInputMode(altsSeen),
    .bufferFillStatus(fillSeen), .bufferEntry(), .resultData(resData));

  conv_core_model core (.clk_sys(clk_sys), .rstn(rstn),
    .convStart(convStart), .lat(lat), .code(code), .convDone(convDone),
    .convResult(convResult));

  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cyc++;
    if (convStart === 1'b1) cnt[0]++;
    if (convIrq === 1'b1) cnt[1]++;
    if (convDone === 1'b1) cnt[2]++;
    if (scanStep === 1'b1) cnt[3]++;
    if (cyc == 60000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done;
    if (mismatches == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, g);
    nTests++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait on an event counter, then let the result settle
  task automatic wait_for(input int k, input int n);
    for (int i = 0; i < 3000 && cnt[k] < n; i++)
      @(posedge clk_sys);
    chk("event count", 32'h1, 32'(cnt[k] >= n));
    repeat (3) @(posedge clk_sys);
  endtask : wait_for

  task automatic pulse(input logic [2:0] t);
    @(posedge clk_sys);
    trig <= t;
    // Held three clocks so the pin survives its synchroniser
    repeat (3) @(posedge clk_sys);
    trig <= 3'h0;
  endtask : pulse

  task automatic t_regs;
    for (int a = 0; a < 16; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b1, OFF_CTRL_TWO, 32'hFFFFFFFF);
    apb(1'b0, OFF_CTRL_TWO, 32'h0);
    chk("ctrl two mask", 32'h0000F43F, rd);
    chk("alternate mode", 32'h1, {31'h0, altsSeen});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask : t_regs

  task automatic t_refs;
    for (int v = 0; v < 8; v++)
    begin
      apb(1'b1, OFF_CTRL_TWO, 32'(v << 13) | 32'h1000);
      @(negedge clk_sys);
      chk("reference decode", {v == 1 || v == 3, v == 2 || v == 3, 1'b1},
          {hiExt, loExt, offset_calibration});
    end
    apb(1'b1, OFF_CTRL_TWO, 32'h0);
  endtask : t_refs

  task automatic t_formats;
    logic        s;
    logic [31:0] e;
    s = ~code[9];
    // Sampling can only be armed once the module is already enabled
    apb(1'b1, OFF_CTRL_ONE, 32'h8000);
    for (int f = 0; f < 8; f++)
    begin
      lat <= f[0] ? 8'h14 : 8'h01;
      apb(1'b1, OFF_CTRL_ONE, 32'h8002 | 32'(f << 8));
      @(negedge clk_sys);
      chk("sampling", 32'h1, {31'h0, sampling});
      apb(1'b1, OFF_CTRL_ONE, 32'h8000 | 32'(f << 8));
      wait_for(2, cnt[2] + 1);
      case (f)
        1: e = {16'h0, {7{s}}, code[8:0]};
        2: e = {16'h0, code, 6'h0};
        3: e = {16'h0, s, code[8:0], 6'h0};
        5: e = {{23{s}}, code[8:0]};
        6: e = {code, 22'h0};
        7: e = {s, code[8:0], 22'h0};
        default: e = {22'h0, code};
      endcase
      apb(1'b0, OFF_RESULT, 32'h0);
      chk("formatted result", e, rd);
      chk("result port", e, resData);
      apb(1'b0, OFF_CTRL_ONE, 32'h0);
      chk("done set", 32'h8001 | 32'(f << 8), rd);
    end
    apb(1'b1, OFF_CTRL_ONE, 32'h8000);
    apb(1'b0, OFF_CTRL_ONE, 32'h0);
    chk("done cleared", 32'h8000, rd);
  endtask : t_formats

  task automatic t_triggers;
    int n;
    // Short conversions so each one ends before the next arming write
    lat <= 8'h01;
    for (int k = 1; k < 4; k++)
    begin
      apb(1'b1, OFF_CTRL_ONE, 32'h8002 | 32'(k << 5));
      n = cnt[0];
      pulse(3'(1 << (k - 1)));
      wait_for(0, n + 1);
      chk("sampling ended", 32'h0, {31'h0, sampling});
    end
    apb(1'b1, OFF_CTRL_ONE, 32'h8082);
    n = cnt[0];
    pulse(3'h7);
    repeat (20) @(posedge clk_sys);
    chk("reserved code", n, cnt[0]);
    apb(1'b1, OFF_CTRL_ONE, 32'hA042);
    idleMode <= 1'b1;
    pulse(3'h2);
    repeat (10) @(posedge clk_sys);
    chk("idle halt", n, cnt[0]);
    idleMode <= 1'b0;
    pulse(3'h2);
    wait_for(0, n + 1);
    n = cnt[0];
    apb(1'b1, OFF_CTRL_ONE, 32'h0042);
    pulse(3'h2);
    repeat (10) @(posedge clk_sys);
    chk("disabled start", n, cnt[0]);
  endtask : t_triggers

  task automatic t_auto;
    int i, d, s, c;
    apb(1'b1, OFF_CLOCK, 32'h0201);
    apb(1'b1, OFF_CTRL_TWO, 32'h0406);
    {i, d, s, c} = {cnt[1], cnt[2], cnt[0], cnt[3]};
    apb(1'b1, OFF_CTRL_ONE, 32'h8000);
    apb(1'b1, OFF_CTRL_ONE, 32'h80F6);
    wait_for(1, i + 1);
    chk("completions per irq", d + 2, cnt[2]);
    repeat (60) @(posedge clk_sys);
    chk("stopped after irq", s + 2, cnt[0]);
    chk("scan steps", c + 2, cnt[3]);
    apb(1'b0, OFF_CTRL_ONE, 32'h0);
    chk("auto start cleared", 32'h0, {31'h0, rd[AUTO_SAMPLE_START_BIT]});
    apb(1'b0, OFF_CTRL_TWO, 32'h0);
    chk("fill status", 32'h1, {31'h0, rd[BUFFER_FILL_STATUS_BIT]});
    chk("fill status pin", 32'h1, {31'h0, fillSeen});
  endtask : t_auto

  task automatic t_disable;
    apb(1'b1, OFF_CTRL_ONE, 32'h0);
    @(negedge clk_sys);
    chk("sampling off", 32'h0, {31'h0, sampling});
    apb(1'b0, OFF_CTRL_ONE, 32'h0);
    chk("done after disable", 32'h0, rd);
    apb(1'b0, OFF_CTRL_TWO, 32'h0);
    chk("fill after disable", 32'h0406, rd);
    apb(1'b1, OFF_CTRL_ONE, 32'h1);
    apb(1'b0, OFF_CTRL_ONE, 32'h0);
    chk("done write one", 32'h0, rd);
  endtask : t_disable

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_refs();
    t_formats();
    t_triggers();
    t_auto();
    t_disable();
    test_done();
  end
endmodule : tb_top
